// >>> common/adc_link_pkg.sv
/*
  package for the converter settings serial port: field layout, reset values,
  link timing constants and the status / control register map of the master end.
  assumes nothing of its surroundings.
*/
package adc_link_pkg;
  localparam int unsigned SYS_CLK_HZ = 250_000_000;
  // settings word layout
  localparam int unsigned WORD_W = 16;
  localparam int unsigned START_BIT = 15;
  localparam int unsigned INPUT_HI = 14;
  localparam int unsigned INPUT_LO = 12;
  localparam int unsigned GAIN_HI = 11;
  localparam int unsigned GAIN_LO = 9;
  localparam int unsigned MODE_BIT = 8;
  localparam int unsigned RATE_HI = 7;
  localparam int unsigned RATE_LO = 5;
  localparam int unsigned TEMP_BIT = 4;
  localparam int unsigned PULLUP_BIT = 3;
  localparam int unsigned QUAL_HI = 2;
  localparam int unsigned QUAL_LO = 1;
  localparam int unsigned RSVD_BIT = 0;
  localparam logic [1:0] QUAL_VALID = 2'h1;
  localparam logic [15:0] SETTINGS_RESET = 16'h058B;
  localparam logic [2:0] GAIN_RESET = 3'h2;
  localparam logic [2:0] RATE_RESET = 3'h4;
  localparam logic [2:0] GAIN_MIN_RANGE = 3'h5;
  // transfer length in link clock periods
  localparam int unsigned XFER_BITS = 32;
  // link idle timeout
  localparam int unsigned TIMEOUT_MS = 28;
  localparam longint unsigned TIMEOUT_CYC = longint'(TIMEOUT_MS) * SYS_CLK_HZ / 1000;
  // master end register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TXWORD = 4'h4;
  localparam logic [3:0] ADDR_RESULT = 4'h8;
  localparam logic [3:0] ADDR_ECHO = 4'hC;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_MASK = 5'h14;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_HOLD = 1;
  localparam int unsigned CTRL_HOLD_LVL = 2;
  localparam int unsigned CTRL_SHORT = 3;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_READY = 1;
  localparam int unsigned EV_W = 2;
  localparam logic [7:0] DEFAULT_HALF_DIV = 8'h08;
endpackage

// >>> common/adc_link_if.sv
/*
  the four-wire serial link between the converter port and its master.
  assumes the bench resolves the shared data-out pin from the enables.
*/
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout_o;
  logic dout_oe_n;
  logic dout_pullup;
  logic dout_line;
  modport device (
    input sclk,
    input cs_n,
    input din,
    output dout_o,
    output dout_oe_n,
    output dout_pullup
  );
  modport host (
    output sclk,
    output cs_n,
    output din,
    input dout_line
  );
endinterface
`default_nettype wire

// >>> src/adc_settings_port.sv
/*
  device end: settings register of the converter behind a mode-1 serial port,
  with the shared data-out / ready pin. the port runs on sys_clk_i and samples
  the link pins through two flip-flops; conversion results come from the user side.
  // Function
  // - gain select in bits 11:9, reset 010
  // - bit 8 chooses continuous or single-shot
  // - bits 7:5 choose sample rate, reset 100
  // - bit 4 selects temperature sensor input
  // - bit 3 pullup on data pin when deselected
  // - store word only when qualifier equals 01
  // - master idles data line to skip update
  // - master writes bit 0 as one
  // - mode 1, serial clock rests low
  // - launch on rising, sample on falling edge
  // - clock low over 28 ms resets port
  // - master keeps clock gaps under 28 ms
  // - bit 15 starts one conversion, reads zero
  // - bits 14:12 select the input pair
  // - chip select fall shows ready state
  // - second half echoes word shifted in first
*/
`timescale 1ns/1ns
`default_nettype none
module adc_settings_port #(
  parameter longint unsigned TIMEOUT_CYC = adc_link_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // serial link
  adc_link_if.device link,
  // converter side
  input wire logic [15:0] result_i,
  input wire logic result_valid_i,
  input wire logic conv_busy_i,
  output logic [2:0] input_select_o,
  output logic [2:0] gain_select_o,
  output logic continuous_o,
  output logic [2:0] rate_select_o,
  output logic temp_sense_select_o,
  output logic [2:0] full_scale_code_o,
  output logic start_pulse_o,
  output logic timeout_o
);
  logic [1:0] sclk_sync_r, cs_sync_r, din_sync_r;
  logic sclk_d_r, cs_d_r;
  logic [15:0] settings_r;
  logic [15:0] shift_in_r, shift_out_r, echo_r, fresh_word_r;
  // the incoming word as it stands once its sixteenth bit arrives
  logic [15:0] word_in;
  logic [5:0] bit_cnt_r;
  logic fresh_r;
  logic dout_r;
  logic [31:0] idle_cnt_r;
  logic start_r;
  logic timeout_r;
  logic sclk_rise, sclk_fall, cs_fall, cs_low, din_s, expired;

  // no 3-state read of the pin: only the second stage is used
  // reset levels match the idle pins, so no false edge follows reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_sync_r <= 2'h0;
      cs_sync_r <= 2'h3;
      din_sync_r <= 2'h0;
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], link.sclk};
      cs_sync_r <= {cs_sync_r[0], link.cs_n};
      din_sync_r <= {din_sync_r[0], link.din};
      sclk_d_r <= sclk_sync_r[1];
      cs_d_r <= cs_sync_r[1];
    end
  end

  assign cs_low = !cs_sync_r[1];
  assign din_s = din_sync_r[1];
  assign word_in = {shift_in_r[14:0], din_s};
  assign sclk_rise = sclk_sync_r[1] && !sclk_d_r;
  assign sclk_fall = !sclk_sync_r[1] && sclk_d_r;
  assign expired = idle_cnt_r >= 32'(TIMEOUT_CYC);

  // idle counter runs while the clock rests low
  // counting only once a transfer has begun keeps a selected but idle port
  // from timing out; a live master may pause with the clock low
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      idle_cnt_r <= 32'h0;
      timeout_r <= 1'b0;
    end else begin
      timeout_r <= 1'b0;
      if (sclk_sync_r[1] || !cs_low || bit_cnt_r == 6'h0) begin
        idle_cnt_r <= 32'h0;
      end else if (expired) begin
        idle_cnt_r <= 32'h0;
        timeout_r <= 1'b1;
      end else begin
        idle_cnt_r <= idle_cnt_r + 32'h1;
      end
    end
  end

  // one-cycle select edge; a level test would keep forcing the ready
  // level over the first data bit until the first falling clock edge
  assign cs_fall = cs_d_r && cs_low;

  // shift engine; deselect or timeout rewinds it
  // the count saturates so a clock train longer than a full transfer
  // cannot wrap back into the word window and store a stray word
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt_r <= 6'h0;
      shift_in_r <= 16'h0;
      echo_r <= 16'h0;
    end else if (!cs_low || timeout_r) begin
      bit_cnt_r <= 6'h0;
    end else if (sclk_fall) begin
      shift_in_r <= word_in;
      bit_cnt_r <= (bit_cnt_r == 6'(adc_link_pkg::XFER_BITS)) ? bit_cnt_r : bit_cnt_r + 6'h1;
      if (bit_cnt_r == 6'(adc_link_pkg::WORD_W - 1)) begin
        echo_r <= {1'b0, word_in[adc_link_pkg::START_BIT - 1:0]};
      end
    end
  end

  // settings register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settings_r <= adc_link_pkg::SETTINGS_RESET;
      start_r <= 1'b0;
    end else begin
      start_r <= 1'b0;
      // only the first word of a transfer, after all sixteen bits
      // bits past the first word are ignored: the echo half never rewrites
      // a timeout in the same cycle wins, so a stale sixteenth fall is dropped
      if (cs_low && !timeout_r && sclk_fall && bit_cnt_r == 6'(adc_link_pkg::WORD_W - 1)
          && word_in[adc_link_pkg::QUAL_HI:adc_link_pkg::QUAL_LO]
          == adc_link_pkg::QUAL_VALID) begin
        // the start bit is never stored, so it reads back as zero
        settings_r <= {1'b0, word_in[adc_link_pkg::START_BIT - 1:adc_link_pkg::QUAL_LO],
          1'b1};
        // start acts on the mode already stored, not on the word arriving
        start_r <= word_in[adc_link_pkg::START_BIT] && settings_r[adc_link_pkg::MODE_BIT]
          && !conv_busy_i;
      end
    end
  end

  // result capture: a new result is latched at once, even mid-transfer
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fresh_r <= 1'b0;
      fresh_word_r <= 16'h0;
    end else begin
      if (result_valid_i) begin
        fresh_word_r <= result_i;
        fresh_r <= 1'b1;
      end else if (cs_low && bit_cnt_r == 6'h0 && sclk_rise) begin
        fresh_r <= 1'b0;
      end
    end
  end

  // output shifter: launched on rising edges
  // the first rise copies the result, so one that lands mid-transfer
  // waits for the next select
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_out_r <= 16'h0;
      dout_r <= 1'b1;
    end else if (!cs_low) begin
      dout_r <= !fresh_r;
    end else if (cs_fall && !sclk_rise) begin
      dout_r <= !fresh_r;
    end else if (sclk_rise) begin
      if (bit_cnt_r == 6'h0) begin
        dout_r <= fresh_word_r[15];
        shift_out_r <= {fresh_word_r[14:0], 1'b0};
      end else if (bit_cnt_r == 6'(adc_link_pkg::WORD_W)) begin
        dout_r <= echo_r[15];
        shift_out_r <= {echo_r[14:0], 1'b0};
      end else begin
        dout_r <= shift_out_r[15];
        shift_out_r <= {shift_out_r[14:0], 1'b0};
      end
    end
  end

  // every code at or above the smallest range saturates there
  function automatic logic [2:0] range_code(input logic [2:0] g);
    range_code = (g >= adc_link_pkg::GAIN_MIN_RANGE) ? adc_link_pkg::GAIN_MIN_RANGE : g;
  endfunction

  assign input_select_o = settings_r[adc_link_pkg::INPUT_HI:adc_link_pkg::INPUT_LO];
  assign gain_select_o = settings_r[adc_link_pkg::GAIN_HI:adc_link_pkg::GAIN_LO];
  assign full_scale_code_o = range_code(gain_select_o);
  assign continuous_o = !settings_r[adc_link_pkg::MODE_BIT];
  assign rate_select_o = settings_r[adc_link_pkg::RATE_HI:adc_link_pkg::RATE_LO];
  assign temp_sense_select_o = settings_r[adc_link_pkg::TEMP_BIT];
  assign start_pulse_o = start_r;
  assign timeout_o = timeout_r;
  // the pin is released only while deselected; the pullup keeps a shared
  // line from floating near mid-rail
  assign link.dout_o = dout_r;
  assign link.dout_oe_n = !cs_low;
  assign link.dout_pullup = !cs_low && settings_r[adc_link_pkg::PULLUP_BIT];
endmodule
`default_nettype wire

// >>> src/adc_link_master.sv
/*
  master end: drives the mode-1 serial link from a clock divider and offers
  its control and results to software over Avalon-MM with waitrequest.
  assumes the device samples on falling edges and the data pin resolved by bench.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_link_master (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // avalon slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // interrupt
  output logic irq_o,
  // serial link
  adc_link_if.host link
);
  typedef enum {IDLE, SETUP, HIGH, LOW, DONE} state_e;
  state_e state_r;
  logic [7:0] div_cnt_r;
  logic [3:0] ctrl_r;
  logic [15:0] tx_r, result_r, echo_r;
  logic [31:0] shift_tx_r, shift_rx_r;
  logic [5:0] bits_r;
  logic [1:0] dout_sync_r;
  logic [1:0] ev_r, mask_r;
  logic ack_r, sclk_r, cs_n_r, din_r;
  logic tick, access, commit, last, ready_seen;

  assign tick = div_cnt_r == 8'h0;
  assign access = (avs_read_i || avs_write_i) && !ack_r;
  // a write lands on the edge that completes the transfer, not the one before
  assign commit = avs_write_i && ack_r;
  assign last = bits_r == 6'(adc_link_pkg::XFER_BITS - 1)
    || (ctrl_r[adc_link_pkg::CTRL_SHORT] && bits_r == 6'(adc_link_pkg::WORD_W - 1));

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout_sync_r <= 2'h3;
    end else begin
      dout_sync_r <= {dout_sync_r[0], link.dout_line};
    end
  end

  // one wait state: answer at the second edge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (access && avs_read_i) begin
      case (avs_address_i)
        {1'b0, adc_link_pkg::ADDR_CTRL}: avs_readdata_o <= {28'h0, ctrl_r};
        {1'b0, adc_link_pkg::ADDR_TXWORD}: avs_readdata_o <= {16'h0, tx_r};
        {1'b0, adc_link_pkg::ADDR_RESULT}: avs_readdata_o <= {16'h0, result_r};
        {1'b0, adc_link_pkg::ADDR_ECHO}: avs_readdata_o <= {16'h0, echo_r};
        adc_link_pkg::ADDR_STATUS: avs_readdata_o <= {30'h0, ev_r};
        adc_link_pkg::ADDR_MASK: avs_readdata_o <= {30'h0, mask_r};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= 4'h0;
      tx_r <= adc_link_pkg::SETTINGS_RESET;
      mask_r <= 2'h0;
    end else begin
      if (state_r == SETUP) begin
        ctrl_r[adc_link_pkg::CTRL_GO] <= 1'b0;
      end
      if (commit) begin
        case (avs_address_i)
          {1'b0, adc_link_pkg::ADDR_CTRL}: ctrl_r <= avs_writedata_i[3:0];
          {1'b0, adc_link_pkg::ADDR_TXWORD}: tx_r <= {avs_writedata_i[15:1], 1'b1};
          adc_link_pkg::ADDR_MASK: mask_r <= avs_writedata_i[1:0];
          default: ;
        endcase
      end
    end
  end

  // sticky events, set wins over the read that clears
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ev_r <= 2'h0;
    end else begin
      ev_r <= ((access && avs_read_i && avs_address_i == adc_link_pkg::ADDR_STATUS)
        ? 2'h0 : ev_r)
        | {ready_seen, state_r == DONE};
    end
  end
  assign ready_seen = state_r == SETUP && tick && !dout_sync_r[1];
  assign irq_o = |(ev_r & mask_r);

  // divider sets the half period of the link clock; well under the idle limit
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt_r <= adc_link_pkg::DEFAULT_HALF_DIV;
    end else if (state_r == IDLE || tick) begin
      div_cnt_r <= adc_link_pkg::DEFAULT_HALF_DIV;
    end else begin
      div_cnt_r <= div_cnt_r - 8'h1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= IDLE;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      din_r <= 1'b0;
      bits_r <= 6'h0;
      shift_tx_r <= 32'h0;
      shift_rx_r <= 32'h0;
      result_r <= 16'h0;
      echo_r <= 16'h0;
    end else begin
      case (state_r)
        IDLE: begin
          sclk_r <= 1'b0;
          if (ctrl_r[adc_link_pkg::CTRL_GO]) begin
            cs_n_r <= 1'b0;
            bits_r <= 6'h0;
            shift_tx_r <= ctrl_r[adc_link_pkg::CTRL_HOLD]
              ? {32{ctrl_r[adc_link_pkg::CTRL_HOLD_LVL]}}
              : {tx_r, tx_r};
            state_r <= SETUP;
          end
        end
        SETUP: if (tick) begin
          state_r <= HIGH;
        end
        HIGH: if (tick) begin
          sclk_r <= 1'b1;
          din_r <= shift_tx_r[31];
          shift_tx_r <= {shift_tx_r[30:0], 1'b0};
          state_r <= LOW;
        end
        LOW: if (tick) begin
          sclk_r <= 1'b0;
          shift_rx_r <= {shift_rx_r[30:0], dout_sync_r[1]};
          bits_r <= bits_r + 6'h1;
          state_r <= last ? DONE : HIGH;
        end
        DONE: begin
          cs_n_r <= 1'b1;
          if (ctrl_r[adc_link_pkg::CTRL_SHORT]) begin
            result_r <= shift_rx_r[15:0];
          end else begin
            result_r <= shift_rx_r[31:16];
            echo_r <= shift_rx_r[15:0];
          end
          state_r <= IDLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.din = din_r;
endmodule
`default_nettype wire

// >>> tb/adc_link_chk.sv
/*
  checker for the serial link between master end and converter port.
  assumes every link signal is sampled by sys_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_link_chk (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  input wire logic dout_pullup
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_high_phase;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence s_low_phase;
    !sclk [*8];
  endsequence
  property p_idle_low;
    cs_n |-> !sclk;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("clock moved while idle");
  property p_high_phase;
    $rose(sclk) |=> s_high_phase;
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("bad high phase");
  property p_low_phase;
    $fell(sclk) && !cs_n |-> s_low_phase;
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("bad low phase");
  property p_gap;
    $fell(sclk) && !cs_n |-> ##[1:40] ($rose(sclk) || cs_n);
  endproperty
  a_gap: assert property (p_gap) else $error("clock gap too long");
  property p_start;
    $fell(cs_n) |-> ##[1:40] $rose(sclk);
  endproperty
  a_start: assert property (p_start) else $error("no clock after select");
  property p_din_hold;
    $fell(sclk) |-> din == $past(din, 2);
  endproperty
  a_din_hold: assert property (p_din_hold) else $error("din moved at sample");
  property p_dout_hold;
    $fell(sclk) && !dout_oe_n |-> dout_o == $past(dout_o, 2);
  endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout moved at sample");
  property p_drive_sel;
    !cs_n [*5] |-> !dout_oe_n && !dout_pullup;
  endproperty
  a_drive_sel: assert property (p_drive_sel) else $error("pin not driven");
  property p_release;
    cs_n [*5] |-> dout_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("pin driven unselected");
endmodule
`default_nettype wire

// >>> tb/adc_config_spi_port_test.sv
/*
  bench: master end and converter port on one link, a second port on a
  bench-driven link for the idle timeout. assumes 250 MHz clock, async reset.
*/
`timescale 1ns/1ns
`default_nettype none
module adc_config_spi_port_test;
  localparam longint unsigned TO_CYC = 2000;
  localparam logic [4:0] A_CTRL = 5'(adc_link_pkg::ADDR_CTRL);
  localparam logic [4:0] A_TX = 5'(adc_link_pkg::ADDR_TXWORD);
  localparam logic [4:0] A_RES = 5'(adc_link_pkg::ADDR_RESULT);
  localparam logic [4:0] A_ECHO = 5'(adc_link_pkg::ADDR_ECHO);
  localparam logic [4:0] A_STAT = adc_link_pkg::ADDR_STATUS;
  localparam logic [4:0] A_MASK = adc_link_pkg::ADDR_MASK;
  logic sys_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic [4:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'h0;
  logic avs_write_i = 1'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic irq_o;
  logic [15:0] result_i = 16'h0000;
  logic result_valid_i = 1'h0;
  logic conv_busy_i = 1'h0;
  logic [2:0] input_select_o;
  logic [2:0] gain_select_o;
  logic continuous_o;
  logic [2:0] rate_select_o;
  logic temp_sense_select_o;
  logic [2:0] full_scale_code_o;
  logic start_pulse_o;
  logic [2:0] gain2;
  logic timeout2;
  logic sclk2 = 1'h0;
  logic cs2_n = 1'h1;
  logic din2 = 1'h0;
  int start_cnt = 0;
  int to_cnt = 0;
  int miscompares = 0;
  int samples_checked = 0;
  adc_link_if link_if();
  adc_link_if link2_if();
  // a floating line shows the inverse of the last driven level
  assign link_if.dout_line = !link_if.dout_oe_n ? link_if.dout_o :
    (link_if.dout_pullup ? 1'h1 : !link_if.dout_o);
  assign link2_if.sclk = sclk2;
  assign link2_if.cs_n = cs2_n;
  assign link2_if.din = din2;
  adc_link_master adc_link_master_inst (.sys_clk_i, .reset_n_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o, .link(link_if));
  adc_settings_port #(.TIMEOUT_CYC(TO_CYC)) adc_settings_port_inst (.sys_clk_i, .reset_n_i,
    .link(link_if), .result_i, .result_valid_i, .conv_busy_i, .input_select_o, .gain_select_o,
    .continuous_o, .rate_select_o, .temp_sense_select_o, .full_scale_code_o, .start_pulse_o,
    .timeout_o());
  adc_settings_port #(.TIMEOUT_CYC(TO_CYC)) adc_settings_port_inst2 (.sys_clk_i, .reset_n_i,
    .link(link2_if), .result_i, .result_valid_i, .conv_busy_i, .input_select_o(),
    .gain_select_o(gain2), .continuous_o(), .rate_select_o(), .temp_sense_select_o(),
    .full_scale_code_o(), .start_pulse_o(), .timeout_o(timeout2));
  adc_link_chk adc_link_chk_inst (.sys_clk_i, .reset_n_i, .sclk(link_if.sclk),
    .cs_n(link_if.cs_n), .din(link_if.din), .dout_o(link_if.dout_o),
    .dout_oe_n(link_if.dout_oe_n), .dout_pullup(link_if.dout_pullup));
  always #2 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    if (start_pulse_o === 1'h1) start_cnt <= start_cnt + 1;
    if (timeout2 === 1'h1) to_cnt <= to_cnt + 1;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic hang(input string msg);
    miscompares++;
    $display("MISMATCH at %0t: %s", $time, msg);
    test_done();
  endtask
  // entered just after a rising edge; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'h0 && n < 100);
    if (n >= 100) hang("bus stuck");
    // read data stand at the completing edge; release only after it
    q = avs_readdata_o;
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
    @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    bus(1'h0, a, 32'h0, q);
  endtask
  // polls status with the interrupt masked, so irq must stay low
  task automatic xfer(input logic [15:0] w, input logic [31:0] ctrl, output logic [31:0] st);
    logic [31:0] q;
    logic irq_seen;
    int n;
    wr(A_TX, {16'h0000, w});
    wr(A_CTRL, ctrl);
    st = 32'h0;
    irq_seen = 1'h0;
    n = 0;
    while (st[adc_link_pkg::EV_DONE] !== 1'h1 && n < 400) begin
      irq_seen = irq_seen | irq_o;
      rd(A_STAT, q);
      st = st | q;
      n++;
    end
    if (n >= 400) hang("transfer stuck");
    check(irq_seen, 1'h0, "masked irq");
  endtask
  task automatic chk_set(input logic [15:0] w);
    check(input_select_o, w[14:12], "input");
    check(gain_select_o, w[11:9], "gain");
    check(full_scale_code_o, (w[11:9] >= 3'h5) ? 3'h5 : w[11:9], "range");
    check(continuous_o, !w[8], "mode");
    check(rate_select_o, w[7:5], "rate");
    check(temp_sense_select_o, w[4], "temp");
    check(link_if.dout_pullup, w[3], "pullup");
  endtask
  task automatic t_reset;
    logic [31:0] q;
    chk_set(adc_link_pkg::SETTINGS_RESET);
    rd(5'h18, q);
    check(q, 32'h0, "unmapped read");
    rd(A_STAT, q);
    check(q, 32'h0, "status idle");
    $display("reset test done");
  endtask
  task automatic t_words;
    logic [31:0] st;
    logic [31:0] q;
    logic [15:0] w;
    xfer(16'h5CF3, 32'h1, st);
    chk_set(16'h5CF3);
    rd(A_ECHO, q);
    check(q[14:1], 14'h2E79, "echo");
    for (int k = 0; k < 4; k++) begin
      if (k != 1) begin
        xfer({13'h1357, 2'(k), 1'h1}, 32'h1, st);
        chk_set(16'h5CF3);
      end
    end
    for (int g = 0; g < 8; g++) begin
      w = {1'h0, 3'(g), 3'(g), 1'h1, 3'(7 - g), 1'(g), 1'h1, 2'h1, 1'h1};
      xfer(w, 32'h1, st);
      chk_set(w);
    end
    $display("word test done");
  endtask
  task automatic t_short_hold;
    logic [31:0] st;
    xfer(16'h098B, 32'h9, st);
    chk_set(16'h098B);
    xfer(16'h5CF3, 32'h3, st);
    chk_set(16'h098B);
    xfer(16'h5CF3, 32'h7, st);
    chk_set(16'h098B);
    $display("short and hold test done");
  endtask
  task automatic t_start;
    logic [31:0] st;
    logic [31:0] q;
    int s0;
    conv_busy_i <= 1'h1;
    s0 = start_cnt;
    xfer(16'h898B, 32'h1, st);
    check(start_cnt - s0, 0, "start while busy");
    conv_busy_i <= 1'h0;
    s0 = start_cnt;
    xfer(16'h898B, 32'h1, st);
    check(start_cnt - s0, 1, "start idle");
    rd(A_ECHO, q);
    check(q[15], 1'h0, "start bit readback");
    $display("start test done");
  endtask
  task automatic t_ready;
    logic [31:0] st;
    logic [31:0] q;
    result_i <= 16'h5AA5;
    result_valid_i <= 1'h1;
    @(posedge sys_clk_i);
    result_valid_i <= 1'h0;
    @(posedge sys_clk_i);
    xfer(16'h0000, 32'h3, st);
    check(st[adc_link_pkg::EV_READY], 1'h1, "new result");
    rd(A_RES, q);
    check(q[15:0], 16'h5AA5, "result");
    xfer(16'h0000, 32'h3, st);
    check(st[adc_link_pkg::EV_READY], 1'h0, "no new result");
    rd(A_RES, q);
    check(q[15:0], 16'h5AA5, "old result");
    $display("ready test done");
  endtask
  task automatic t_irq;
    logic [31:0] q;
    int n;
    wr(A_MASK, 32'h1);
    wr(A_CTRL, 32'h3);
    n = 0;
    while (irq_o !== 1'h1 && n < 3000) begin
      @(negedge sys_clk_i);
      n++;
    end
    if (n >= 3000) hang("no interrupt");
    @(posedge sys_clk_i);
    rd(A_STAT, q);
    check(q[adc_link_pkg::EV_DONE], 1'h1, "done status");
    check(irq_o, 1'h0, "irq cleared");
    rd(A_STAT, q);
    check(q, 32'h0, "status cleared");
    wr(A_MASK, 32'h0);
    $display("interrupt test done");
  endtask
  // bench as master: data launched with the rising link edge, 64 ns period
  task automatic send2(input logic [15:0] w, input int nbits);
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk2 <= 1'h1;
      din2 <= w[i];
      repeat (8) @(posedge sys_clk_i);
      sclk2 <= 1'h0;
      repeat (8) @(posedge sys_clk_i);
    end
  endtask
  task automatic t_timeout;
    int c0;
    cs2_n <= 1'h0;
    repeat (8) @(posedge sys_clk_i);
    send2(16'h0E8B, 12);
    c0 = to_cnt;
    repeat (TO_CYC + 50) @(posedge sys_clk_i);
    check(to_cnt - c0, 1, "timeout count");
    check(gain2, adc_link_pkg::GAIN_RESET, "partial word");
    send2(16'h098B, 16);
    cs2_n <= 1'h1;
    repeat (8) @(posedge sys_clk_i);
    check(gain2, 3'h4, "word after timeout");
    $display("timeout test done");
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    reset_n_i <= 1'h1;
    @(posedge sys_clk_i);
    t_reset();
    t_words();
    t_short_hold();
    t_start();
    t_ready();
    t_irq();
    t_timeout();
    test_done();
  end
endmodule
`default_nettype wire
